// ---- verilog/asmc_pkg.sv ----
// Constants and types for the serial mode-control block
package asmc_pkg;
    localparam int CMD_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 12;
    localparam int SAMPLE_W = 10;
    localparam int TRIM_W = 6;
    localparam int CM_W = 2;
    localparam int CNT_W = 5;
    localparam logic [4:0] CMD_BITS = 5'h10;
    // Function addresses
    localparam logic [3:0] ADDR_FULL_EN = 4'h0;
    localparam logic [3:0] ADDR_DAC1 = 4'h1;
    localparam logic [3:0] ADDR_DAC2 = 4'h2;
    localparam logic [3:0] ADDR_DAC3 = 4'h3;
    localparam logic [3:0] ADDR_IOFS = 4'h4;
    localparam logic [3:0] ADDR_QOFS = 4'h5;
    localparam logic [3:0] ADDR_CMSEL = 4'h6;
    localparam logic [3:0] ADDR_ADC = 4'h7;
    localparam logic [3:0] ADDR_SHORT_EN = 4'h8;
    // Enable word fields
    localparam int AUX_PWR_BIT = 9;
    localparam logic [11:0] FULL_EN_RESET = 12'h004;
    localparam logic [11:0] FULL_EN_MASK = 12'h3ff;
    localparam logic [3:0] EN_FULL_POWER_DOWN = 4'h0;
    localparam logic [3:0] EN_IDLE = 4'h1;
    localparam logic [3:0] EN_LOW_POWER_HOLD = 4'h2;
    localparam logic [3:0] EN_EXT1 = 4'h3;
    localparam logic [3:0] EN_EXT2 = 4'h4;
    localparam logic [3:0] EN_EXT3 = 4'h5;
    localparam logic [3:0] EN_EXT4 = 4'h6;
    localparam logic [11:0] WORD_RESET = 12'h000;
    localparam logic [9:0] BUS_PULLUP = 10'h3ff;
    typedef enum logic [3:0] {
        ASMC_IDLE_S = 4'b0001,
        ASMC_SHIFT_S = 4'b0010,
        ASMC_DONE_S = 4'b0100,
        ASMC_BAD_S = 4'b1000
    } asmc_ser_state_t;
endpackage

// ---- verilog/asmc_core.sv ----
// Serial mode-control and transmit sample latch of the analog front end
`timescale 1ns/1ps
module asmc_core (
    input wire logic i_ref_clk,            // System clock, 100 MHz
    input wire logic i_srst,               // Synchronous reset, high
    input wire logic i_sclk,               // Serial clock pin
    input wire logic i_cs_n,               // Serial select, low active
    input wire logic i_sdin,               // Serial data pin
    input wire logic i_tr_pin,             // Transmit/receive pin, 1 = tx
    input wire logic i_conv_clk,           // Converter clock pin
    input wire logic [9:0] i_bus,          // Shared sample bus, in
    input wire logic [9:0] i_rx_sample,    // Receive ADC word to drive
    output logic [9:0] o_bus,              // Shared sample bus, out
    output logic o_bus_oe,                 // Bus driven by device
    output logic o_bus_pullup,             // Weak pull-up active
    output logic [9:0] o_inphase_tx_sample,    // I DAC output word
    output logic [9:0] o_quadrature_tx_sample, // Q DAC output word
    output logic o_rx_adc_on,              // Receive ADC powered
    output logic o_tx_dac_on,              // Transmit DAC powered
    output logic o_clk_on,                 // Clock tree powered
    output logic o_ref_on,                 // Reference powered
    output logic o_full_power_down,        // Full shutdown state
    output logic o_low_power_hold,         // Standby state
    output logic o_idle,                   // Idle state
    output logic o_tx_mode,                // Transmit state active
    output logic [11:0] o_full_enable_word,    // Held enable word
    output logic [11:0] o_aux_dac_one_code,    // Aux-DAC 1 code
    output logic [11:0] o_aux_dac_two_code,    // Aux-DAC 2 code
    output logic [11:0] o_aux_dac_three_code,  // Aux-DAC 3 code
    output logic [5:0] o_inphase_offset_trim,  // I offset trim
    output logic [5:0] o_quadrature_offset_trim, // Q offset trim
    output logic [1:0] o_common_mode_select,   // Common-mode code
    output logic [11:0] o_aux_adc_start,       // Aux-ADC command word
    output logic o_aux_adc_start_pulse,        // Aux-ADC start strobe
    output logic [3:0] o_function_address      // Last selected function
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic looks

    logic [1:0] sclk_sy, cs_sy, sd_sy, tr_sy, cc_sy;
    logic [1:0] next_sclk_sy, next_cs_sy, next_sd_sy, next_tr_sy;
    logic [1:0] next_cc_sy;
    logic [9:0] bus_sy1, bus_sy2, next_bus_sy1, next_bus_sy2;
    logic sclk_d, cc_d, next_sclk_d, next_cc_d;

    always_comb begin
        next_sclk_sy = {sclk_sy[0], i_sclk};
        next_cs_sy = {cs_sy[0], i_cs_n};
        next_sd_sy = {sd_sy[0], i_sdin};
        next_tr_sy = {tr_sy[0], i_tr_pin};
        next_cc_sy = {cc_sy[0], i_conv_clk};
        // Same two-flop delay keeps bus aligned with converter clock
        next_bus_sy1 = i_bus;
        next_bus_sy2 = bus_sy1;
        next_sclk_d = sclk_sy[1];
        next_cc_d = cc_sy[1];
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sclk_sy <= 2'h0;
            cs_sy <= 2'h3;
            sd_sy <= 2'h0;
            tr_sy <= 2'h0;
            cc_sy <= 2'h0;
            bus_sy1 <= 10'h000;
            bus_sy2 <= 10'h000;
            sclk_d <= 1'b0;
            cc_d <= 1'b0;
        end else begin
            sclk_sy <= next_sclk_sy;
            cs_sy <= next_cs_sy;
            sd_sy <= next_sd_sy;
            tr_sy <= next_tr_sy;
            cc_sy <= next_cc_sy;
            bus_sy1 <= next_bus_sy1;
            bus_sy2 <= next_bus_sy2;
            sclk_d <= next_sclk_d;
            cc_d <= next_cc_d;
        end
    end

    wire sclk_rise = sclk_sy[1] & ~sclk_d;
    wire cc_rise = cc_sy[1] & ~cc_d;
    wire cc_fall = ~cc_sy[1] & cc_d;
    wire cs_n = cs_sy[1];
    wire tr = tr_sy[1];

    ////////////////////////////////////////////////////////////////////
    // Serial receiver; never gated by power state

    asmc_pkg::asmc_ser_state_t st, next_st;
    logic [15:0] shreg, next_shreg;
    logic [4:0] bitcnt, next_bitcnt;
    logic cmd_valid;

    always_comb begin
        next_st = st;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        cmd_valid = 1'b0;
        case (st)
            asmc_pkg::ASMC_IDLE_S: begin
                next_bitcnt = '0;
                if (!cs_n) begin
                    next_st = asmc_pkg::ASMC_SHIFT_S;
                end
            end
            asmc_pkg::ASMC_SHIFT_S: begin
                if (cs_n) begin
                    // Exactly sixteen bits or the word is dropped
                    if (bitcnt == asmc_pkg::CMD_BITS) begin
                        next_st = asmc_pkg::ASMC_DONE_S;
                    end else begin
                        next_st = asmc_pkg::ASMC_IDLE_S;
                    end
                end else if (sclk_rise) begin
                    // MSB first, A0 lands in bit 0
                    next_shreg = {shreg[14:0], sd_sy[1]};
                    if (bitcnt == asmc_pkg::CMD_BITS) begin
                        next_st = asmc_pkg::ASMC_BAD_S;
                    end else begin
                        next_bitcnt = bitcnt + 5'h01;
                    end
                end
            end
            asmc_pkg::ASMC_DONE_S: begin
                cmd_valid = 1'b1;
                next_st = asmc_pkg::ASMC_IDLE_S;
            end
            asmc_pkg::ASMC_BAD_S: begin
                // Overlong frame waits out select, then is discarded
                if (cs_n) begin
                    next_st = asmc_pkg::ASMC_IDLE_S;
                end
            end
            default: next_st = asmc_pkg::ASMC_IDLE_S;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st <= asmc_pkg::ASMC_IDLE_S;
            shreg <= 16'h0000;
            bitcnt <= 5'h00;
        end else begin
            st <= next_st;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Function word registers, address decode

    // Split word into address and data
    wire [3:0] cmd_addr = shreg[3:0];
    wire [11:0] cmd_data = shreg[15:4];

    logic [11:0] en_w, dac1, dac2, dac3, adcw;
    logic [5:0] iofs, qofs;
    logic [1:0] cms;
    logic [3:0] fsel;
    logic adc_pulse;
    logic [11:0] next_en_w, next_dac1, next_dac2, next_dac3, next_adcw;
    logic [5:0] next_iofs, next_qofs;
    logic [1:0] next_cms;
    logic [3:0] next_fsel;
    logic next_adc_pulse;

    always_comb begin
        // Unwritten words hold
        next_en_w = en_w;
        next_dac1 = dac1;
        next_dac2 = dac2;
        next_dac3 = dac3;
        next_adcw = adcw;
        next_iofs = iofs;
        next_qofs = qofs;
        next_cms = cms;
        next_fsel = fsel;
        next_adc_pulse = 1'b0;
        if (cmd_valid) begin
            next_fsel = cmd_addr;
            if (cmd_addr == asmc_pkg::ADDR_FULL_EN) begin
                // Reserved top bits forced low
                next_en_w = cmd_data & asmc_pkg::FULL_EN_MASK;
            end else if (cmd_addr == asmc_pkg::ADDR_DAC1) begin
                next_dac1 = cmd_data;
            end else if (cmd_addr == asmc_pkg::ADDR_DAC2) begin
                next_dac2 = cmd_data;
            end else if (cmd_addr == asmc_pkg::ADDR_DAC3) begin
                next_dac3 = cmd_data;
            end else if (cmd_addr == asmc_pkg::ADDR_IOFS) begin
                next_iofs = cmd_data[5:0];
            end else if (cmd_addr == asmc_pkg::ADDR_QOFS) begin
                next_qofs = cmd_data[5:0];
            end else if (cmd_addr == asmc_pkg::ADDR_CMSEL) begin
                next_cms = cmd_data[1:0];
            end else if (cmd_addr == asmc_pkg::ADDR_ADC) begin
                next_adcw = cmd_data;
                next_adc_pulse = 1'b1;
            end else if (cmd_addr == asmc_pkg::ADDR_SHORT_EN) begin
                // Only low four bits; aux power bits kept
                next_en_w = {en_w[11:4], cmd_data[3:0]};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            en_w <= asmc_pkg::FULL_EN_RESET;
            dac1 <= asmc_pkg::WORD_RESET;
            dac2 <= asmc_pkg::WORD_RESET;
            dac3 <= asmc_pkg::WORD_RESET;
            adcw <= asmc_pkg::WORD_RESET;
            iofs <= 6'h00;
            qofs <= 6'h00;
            cms <= 2'h0;
            fsel <= asmc_pkg::ADDR_FULL_EN;
            adc_pulse <= 1'b0;
        end else begin
            en_w <= next_en_w;
            dac1 <= next_dac1;
            dac2 <= next_dac2;
            dac3 <= next_dac3;
            adcw <= next_adcw;
            iofs <= next_iofs;
            qofs <= next_qofs;
            cms <= next_cms;
            fsel <= next_fsel;
            adc_pulse <= next_adc_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power and switching mode decode

    wire [3:0] low_enable_bits = en_w[3:0];
    wire aux_converter_power_bit = en_w[asmc_pkg::AUX_PWR_BIT];
    logic full_power_down, idle, low_power_hold, rx_on, tx_on, clk_on, ref_on, txm, active;

    always_comb begin
        full_power_down = 1'b0;
        idle = 1'b0;
        low_power_hold = 1'b0;
        rx_on = 1'b0;
        tx_on = 1'b0;
        clk_on = 1'b1;
        ref_on = 1'b1;
        txm = 1'b0;
        active = 1'b0;
        // Pin ignored in the three low-power states
        if (aux_converter_power_bit && low_enable_bits[2:0] == 3'h0) begin
            full_power_down = 1'b1;
            clk_on = 1'b0;
            ref_on = 1'b0;
        end else if (low_enable_bits[2:0] == 3'h1) begin
            idle = 1'b1;
        end else if (aux_converter_power_bit &&
                     low_enable_bits[2:0] == 3'h2) begin
            low_power_hold = 1'b1;
            clk_on = 1'b0;
        end else if (low_enable_bits == asmc_pkg::EN_EXT1) begin
            active = 1'b1;
            txm = tr;
            rx_on = ~tr;
            tx_on = 1'b1;
        end else if (low_enable_bits == asmc_pkg::EN_EXT3) begin
            active = 1'b1;
            txm = tr;
            rx_on = ~tr;
            tx_on = tr;
        end else if (low_enable_bits == asmc_pkg::EN_EXT4) begin
            active = 1'b1;
            txm = tr;
            rx_on = 1'b1;
            tx_on = 1'b1;
        end else begin
            // Default scheme and unsupported codes
            active = 1'b1;
            txm = tr;
            rx_on = 1'b1;
            tx_on = tr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit sample latch on converter clock edges

    logic [9:0] i_cap, q_cap, i_out, q_out, rx_q;
    logic [9:0] next_i_cap, next_q_cap, next_i_out, next_q_out;
    logic [9:0] i_pair, next_i_pair;
    logic q_pend, next_q_pend, i_seen, next_i_seen;

    always_comb begin
        next_i_cap = i_cap;
        next_q_cap = q_cap;
        next_i_out = i_out;
        next_q_out = q_out;
        next_q_pend = q_pend;
        next_i_pair = i_pair;
        next_i_seen = i_seen;
        if (active && txm && tx_on) begin
            if (cc_fall) begin
                next_i_cap = bus_sy2;
                next_i_seen = 1'b1;
            end
            if (cc_rise) begin
                // Outputs move together from last full pair
                if (q_pend) begin
                    next_i_out = i_pair;
                    next_q_out = q_cap;
                end
                // Park I beside its Q; a newer I must not split the pair
                next_i_pair = i_cap;
                next_q_cap = bus_sy2;
                next_q_pend = i_seen;
            end
        end else begin
            next_q_pend = 1'b0;
            next_i_seen = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            i_cap <= 10'h000;
            q_cap <= 10'h000;
            i_out <= 10'h000;
            q_out <= 10'h000;
            q_pend <= 1'b0;
            rx_q <= 10'h000;
            i_pair <= 10'h000;
            i_seen <= 1'b0;
        end else begin
            i_cap <= next_i_cap;
            q_cap <= next_q_cap;
            i_out <= next_i_out;
            q_out <= next_q_out;
            q_pend <= next_q_pend;
            rx_q <= i_rx_sample;
            i_pair <= next_i_pair;
            i_seen <= next_i_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs; bus direction is exclusive

    assign o_bus = rx_q;
    assign o_bus_oe = active & ~txm & rx_on;
    assign o_bus_pullup = full_power_down | idle | low_power_hold;
    assign o_inphase_tx_sample = i_out;
    assign o_quadrature_tx_sample = q_out;
    assign o_rx_adc_on = rx_on;
    assign o_tx_dac_on = tx_on;
    assign o_clk_on = clk_on;
    assign o_ref_on = ref_on;
    assign o_full_power_down = full_power_down;
    assign o_low_power_hold = low_power_hold;
    assign o_idle = idle;
    assign o_tx_mode = active & txm;
    assign o_full_enable_word = en_w;
    assign o_aux_dac_one_code = dac1;
    assign o_aux_dac_two_code = dac2;
    assign o_aux_dac_three_code = dac3;
    assign o_inphase_offset_trim = iofs;
    assign o_quadrature_offset_trim = qofs;
    assign o_common_mode_select = cms;
    assign o_aux_adc_start = adcw;
    assign o_aux_adc_start_pulse = adc_pulse;
    assign o_function_address = fsel;

endmodule // asmc_core

// ---- verif/asmc_core_monitor.sv ----
// Concurrent checks on the mode-control block ports
`timescale 1ns/1ps
module asmc_core_monitor (
    input wire logic i_ref_clk, // System clock
    input wire logic i_srst, // Sync reset
    input wire logic i_cs_n, // Serial select
    input wire logic i_conv_clk, // Converter clock
    input wire logic o_bus_oe, // Device drives bus
    input wire logic o_bus_pullup, // Bus pull-up
    input wire logic [9:0] o_inphase_tx_sample, // I DAC word
    input wire logic [9:0] o_quadrature_tx_sample, // Q DAC word
    input wire logic o_rx_adc_on, // Rx ADC power
    input wire logic o_tx_dac_on, // Tx DAC power
    input wire logic o_clk_on, // Clock power
    input wire logic o_ref_on, // Reference power
    input wire logic o_full_power_down, // Shutdown
    input wire logic o_low_power_hold, // Standby
    input wire logic o_idle, // Idle
    input wire logic o_tx_mode, // Transmit state
    input wire logic [11:0] o_full_enable_word, // Enable word
    input wire logic [11:0] o_aux_dac_one_code, // Aux-DAC 1 code
    input wire logic o_aux_adc_start_pulse, // Aux-ADC strobe
    input wire logic [3:0] o_function_address // Last function
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////
    // Power states: each gates exactly its own blocks
    property p_full_power_down;
        o_full_power_down |-> !(o_rx_adc_on || o_tx_dac_on)
            && !(o_clk_on || o_ref_on);
    endproperty
    a_full_power_down: assert property (p_full_power_down)
        else $error("shutdown left a block powered");
    property p_idle;
        o_idle |-> o_clk_on && o_ref_on && !o_rx_adc_on && !o_tx_dac_on;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle power pattern wrong");
    property p_low_power_hold;
        o_low_power_hold |-> o_ref_on && !o_clk_on && !o_rx_adc_on
            && !o_tx_dac_on;
    endproperty
    a_low_power_hold: assert property (p_low_power_hold)
        else $error("standby power pattern wrong");
    property p_pull;
        (o_full_power_down || o_idle || o_low_power_hold)
            |-> o_bus_pullup && !o_bus_oe;
    endproperty
    a_pull: assert property (p_pull)
        else $error("bus not pulled up in low power");
    property p_excl;
        o_bus_oe |-> !o_tx_mode;
    endproperty
    a_excl: assert property (p_excl)
        else $error("bus driven while transmitting");
    property p_fast;
        o_full_enable_word[3:0] == 4'h6 |-> o_rx_adc_on && o_tx_dac_on;
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast scheme dropped a converter");
    ////////////////////////////////////////////////////////////////////////
    // Serial words and sample outputs only move at their causes
    property p_frame;
        $changed(o_aux_dac_one_code) |-> i_cs_n;
    endproperty
    a_frame: assert property (p_frame)
        else $error("word changed inside a frame");
    property p_pulse;
        o_aux_adc_start_pulse |-> o_function_address == 4'h7
            ##1 !o_aux_adc_start_pulse;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("aux converter strobe wrong");
    property p_dac;
        ($changed(o_inphase_tx_sample) || $changed(o_quadrature_tx_sample))
            |-> i_conv_clk;
    endproperty
    a_dac: assert property (p_dac)
        else $error("DAC outputs moved off the rising phase");
    c_full_power_down: cover property (o_full_power_down);
    c_pulse: cover property (o_aux_adc_start_pulse);
    c_tx: cover property (o_tx_mode && $changed(o_inphase_tx_sample));
endmodule // asmc_core_monitor

bind asmc_core asmc_core_monitor mon_u (.i_ref_clk, .i_srst, .i_cs_n,
    .i_conv_clk, .o_bus_oe, .o_bus_pullup, .o_inphase_tx_sample,
    .o_quadrature_tx_sample, .o_rx_adc_on, .o_tx_dac_on, .o_clk_on,
    .o_ref_on, .o_full_power_down, .o_low_power_hold, .o_idle, .o_tx_mode,
    .o_full_enable_word, .o_aux_dac_one_code, .o_aux_adc_start_pulse,
    .o_function_address);

// ---- verif/asmc_host_model.sv ----
// Host controller model: serial port, T/R pin, converter clock, bus
`timescale 1ns/1ps
module asmc_host_model (
    input wire logic i_ref_clk, // System clock
    output logic o_sclk, // Serial clock, still outside frames
    output logic o_cs_n, // Serial select, low active
    output logic o_sdin, // Serial data
    output logic o_tr_pin, // 1 = transmit
    output logic o_conv_clk, // Converter clock, idles high
    output logic [9:0] o_bus, // Tx sample word
    output logic o_bus_oe // Host drives bus
);
    // Quiet pins at time zero
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdin = 1'b0;
        o_tr_pin = 1'b0;
        o_conv_clk = 1'b1;
        o_bus = 10'h000;
        o_bus_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Framed command, MSB first; n other than 16 makes a bad frame
    task automatic send(input logic [15:0] w, input int n);
        o_cs_n <= 1'b0;
        tick(4);
        for (int b = 15; b > 15 - n; b--) begin
            // Bits past sixteen wrap to the top, so long frames stay known
            o_sdin <= w[(b + 16) % 16];
            tick(4);
            o_sclk <= 1'b1;
            tick(4);
            o_sclk <= 1'b0;
        end
        tick(4);
        o_cs_n <= 1'b1;
        o_sdin <= ~o_sdin; // Released line must not look stale
        tick(12);
    endtask
    // Host drives the bus only while transmitting
    task automatic set_tr(input logic pin, input logic drive);
        o_tr_pin <= pin;
        o_bus_oe <= drive;
        tick(8);
    endtask
    // One pair: I settled around the fall, Q around the rise
    task automatic pair(input logic [9:0] i_word, input logic [9:0] q_word);
        o_bus <= i_word;
        tick(4);
        o_conv_clk <= 1'b0;
        tick(4);
        o_bus <= q_word;
        tick(4);
        o_conv_clk <= 1'b1;
        tick(4); // Eight cycles low, eight high: 160 ns period
    endtask
endmodule // asmc_host_model

// ---- verif/tb.sv ----
// Self-checking bench for the serial mode-control block
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [9:0] rx_sample = 10'h2c3;
    logic sclk, cs_n, sdin, tr, conv, host_oe, dut_oe, pu, pd, hd, idl;
    logic rx_on, tx_on, txm, pulse;
    logic [9:0] host_bus, dut_bus, bus_w, iq_i, iq_q;
    logic [11:0] full_w, dac1, dac2, dac3, adc_w;
    logic [5:0] itrim, qtrim;
    logic [1:0] cm;
    logic [3:0] fadr;
    int err_total = 0;
    int check_count = 0;
    int pulse_n = 0;
    logic [11:0] pw_word [11] = '{12'h200, 12'h001, 12'h202, 12'h003,
        12'h003, 12'h004, 12'h004, 12'h005, 12'h005, 12'h006, 12'h006};
    logic [10:0] pw_pin = 11'b10101010011;
    logic [6:0] pw_exp [11] = '{7'h0c, 7'h0a, 7'h09, 7'h70, 7'h20,
        7'h50, 7'h60, 7'h50, 7'h20, 7'h70, 7'h60};
    always #5 clk = ~clk;
    // Wire level: host, then device, else the weak pull-up
    assign bus_w = host_oe ? host_bus : (dut_oe ? dut_bus : 10'h3ff);
    asmc_host_model host_u (.i_ref_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_sdin(sdin), .o_tr_pin(tr), .o_conv_clk(conv), .o_bus(host_bus),
        .o_bus_oe(host_oe));
    asmc_core dut_u (.i_ref_clk(clk), .i_srst(srst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdin(sdin), .i_tr_pin(tr), .i_conv_clk(conv),
        .i_bus(bus_w), .i_rx_sample(rx_sample), .o_bus(dut_bus),
        .o_bus_oe(dut_oe), .o_bus_pullup(pu), .o_inphase_tx_sample(iq_i),
        .o_quadrature_tx_sample(iq_q), .o_rx_adc_on(rx_on),
        .o_tx_dac_on(tx_on), .o_clk_on(), .o_ref_on(),
        .o_full_power_down(pd), .o_low_power_hold(hd), .o_idle(idl),
        .o_tx_mode(txm), .o_full_enable_word(full_w),
        .o_aux_dac_one_code(dac1), .o_aux_dac_two_code(dac2),
        .o_aux_dac_three_code(dac3), .o_inphase_offset_trim(itrim),
        .o_quadrature_offset_trim(qtrim), .o_common_mode_select(cm),
        .o_aux_adc_start(adc_w), .o_aux_adc_start_pulse(pulse),
        .o_function_address(fadr));
    // Strobes are one cycle wide, so count them as they pass
    always @(posedge clk) begin
        if (pulse === 1'b1) begin
            pulse_n++;
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        host_u.send({d, a}, 16);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(full_w, 12'h004);
        chk({8'h00, fadr}, 12'h000);
        // Power states first; later frames land with code 6 in the enable word
        for (int r = 0; r < 11; r++) begin
            host_u.set_tr(pw_pin[r], pw_pin[r] && r > 1);
            wr(4'h0, pw_word[r]);
            chk({5'h00, rx_on, tx_on, dut_oe, pu, pd, idl, hd},
                {5'h00, pw_exp[r]});
            if (pw_exp[r][4]) begin
                chk({2'h0, dut_bus}, {2'h0, rx_sample});
            end
        end
        wr(4'h1, 12'ha5c);
        wr(4'h2, 12'h123);
        wr(4'h3, 12'hfff);
        wr(4'h4, 12'hfea);
        wr(4'h5, 12'h015);
        wr(4'h6, 12'h003);
        wr(4'h7, 12'h7ab);
        host_u.send(16'h5552, 15);
        host_u.send(16'h1231, 17);
        chk(dac1, 12'ha5c);
        chk(dac2, 12'h123);
        chk(dac3, 12'hfff);
        chk({6'h00, itrim}, 12'h02a);
        chk({6'h00, qtrim}, 12'h015);
        chk({10'h000, cm}, 12'h003);
        chk(adc_w, 12'h7ab);
        chk({8'h00, fadr}, 12'h007);
        chk(pulse_n[11:0], 12'h001);
        wr(4'h0, 12'h206);
        wr(4'h8, 12'h005);
        chk(full_w, 12'h205);
        wr(4'h0, 12'hc04);
        chk(full_w, 12'h004);
        // Transmit pairs: outputs trail by one converter cycle
        host_u.pair(10'h155, 10'h2aa);
        host_u.pair(10'h0f0, 10'h30f);
        chk({2'h0, iq_i}, 12'h155);
        chk({2'h0, iq_q}, 12'h2aa);
        host_u.pair(10'h3ff, 10'h001);
        chk({2'h0, iq_i}, 12'h0f0);
        chk({2'h0, iq_q}, 12'h30f);
        // Receive: bus traffic must not reach the DAC outputs
        // Pair still pending when transmit ends is dropped
        host_u.set_tr(1'b0, 1'b0);
        host_u.pair(10'h0aa, 10'h055);
        host_u.pair(10'h0aa, 10'h055);
        chk({2'h0, iq_i}, 12'h0f0);
        chk({2'h0, iq_q}, 12'h30f);
        end_of_test();
    end
    // Watchdog well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule // tb
